// ### rtl/acs_sequencer.sv
// module: conversion sequencer for a 10-bit converter with an AHB-Lite register slave
//
// Summary of operation
// - power flows only while enable is set and the power gate is clear; selections reach the converter even while power is off
// - converter returns a 10-bit code, zero at ground, full at reference
// - two-bit reference select picks supply, external pin or internal reference
// - result right adjusted by default, left adjusted when select bit set
// - low byte read locks result until high byte read; late results dropped
// - done flag still sets when a result is dropped
// - writing start begins a conversion; bit stays high until completion
// - channel change during a conversion takes effect afterwards
// - rising edge of chosen trigger resets prescaler and starts a conversion
// - edges during conversion ignored; held trigger needs fresh edge
// - trigger flags set regardless of enables; software must clear them
// - done flag as trigger gives free running after a software start
// - start still works with auto trigger; start reads one while converting
// - prescaler divides system clock, counts with enable, held reset otherwise
// - software start begins at next rising converter clock edge
// - normal conversion 13 cycles; first after enable 25 cycles
// - sample-and-hold at 1.5 cycles normal, 13.5 first
// - completion writes result, sets done flag, clears start in single mode
// - auto triggered: hold at 2 cycles, conversion 13.5 cycles plus sync
// - free running restarts at once, start stays high, hold 2.5, 14 cycles
// - selections follow writes until start, resume in the last cycle
`timescale 1ns/1ps
module acs_sequencer
(
  input  wire logic                     hclk,        // system clock, 50 MHz
  input  wire logic                     hresetn,     // asynchronous reset, active low
  input  wire logic                     hsel,        // slave select
  input  wire logic [31:0]              haddr,       // byte address
  input  wire logic [1:0]               htrans,      // transfer type
  input  wire logic                     hwrite,      // write when high
  input  wire logic [2:0]               hsize,       // transfer size
  input  wire logic [31:0]              hwdata,      // write data
  input  wire logic                     hready,      // bus ready
  output logic      [31:0]              hrdata,      // read data
  output logic                          hreadyout,   // slave ready
  output logic                          hresp,       // always OKAY
  input  wire logic [acs_pkg::NTRIG-1:0] trig_in,    // trigger source events, async
  input  wire logic                     irq_ack,     // done interrupt serviced, same clock
  input  wire logic [9:0]               conv_code,   // converter successive approx result
  output logic                          conv_power,  // converter supplied
  output acs_pkg::acs_sel_t             conv_sel,    // applied reference and channel
  output logic                          conv_sample, // sample-and-hold pulse
  output logic                          conv_clk_en, // converter clock enable pulse
  output logic                          done_irq     // done flag and interrupt enable
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    acs_pkg::acs_aphase_t   ap;
    logic [31:0]            rdata;
    logic                   gate;
    logic [7:0]             ctrl_a;
    logic [3:0]             ctrl_b;
    acs_pkg::acs_sel_t      sel_sw;
    acs_pkg::acs_sel_t      sel_buf;
    logic [9:0]             result;
    logic                   locked;
    logic [acs_pkg::NTRIG-1:0] s1, s2, s3;
    logic [acs_pkg::NTRIG-1:0] tflag;
    logic [acs_pkg::NTRIG-1:0] lvl;
    logic                   src_prev;
    logic [6:0]             pre;
    logic                   half;
    acs_pkg::acs_phase_t    phase;
    acs_pkg::acs_kind_t     kind;
    logic                   first;
    logic                   start_pend;
    logic                   chain;
    logic [5:0]             hcnt;
    logic                   sample;
    logic                   clk_en;
    logic                   pwr;
    logic                   irq;
  } acs_state_t;

  acs_state_t r, next_r;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [6:0] div_mask(input logic [2:0] ps);
    logic [6:0] m;
    // half period minus one; codes zero and one both give the fastest rate
    m = 7'h00;
    if (ps > 3'h1)
      m = 7'(({7'h00, 1'b1} << (ps - 3'h1)) - 8'h01);
    return m;
  endfunction

  function automatic logic [5:0] conv_len(input acs_pkg::acs_kind_t k);
    logic [5:0] v;
    v = acs_pkg::HALF_NORMAL;
    unique case (k)
      acs_pkg::ACS_K_NORMAL: v = acs_pkg::HALF_NORMAL;
      acs_pkg::ACS_K_FIRST:  v = acs_pkg::HALF_FIRST;
      acs_pkg::ACS_K_AUTO:   v = acs_pkg::HALF_AUTO;
      acs_pkg::ACS_K_FREE:   v = acs_pkg::HALF_FREE;
    endcase
    return v;
  endfunction

  function automatic logic [5:0] sh_point(input acs_pkg::acs_kind_t k);
    logic [5:0] v;
    v = acs_pkg::SH_NORMAL;
    unique case (k)
      acs_pkg::ACS_K_NORMAL: v = acs_pkg::SH_NORMAL;
      acs_pkg::ACS_K_FIRST:  v = acs_pkg::SH_FIRST;
      acs_pkg::ACS_K_AUTO:   v = acs_pkg::SH_AUTO;
      acs_pkg::ACS_K_FREE:   v = acs_pkg::SH_FREE;
    endcase
    return v;
  endfunction

  logic                   enable, ate, busy, wr, rd, done_evt, half_tick, trig_edge;
  logic [2:0]             tsel;
  logic [acs_pkg::NTRIG-1:0] trig_ok;
  logic [11:0]            a;
  logic [15:0]            adj;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_r      = r;
    enable      = r.ctrl_a[acs_pkg::A_ENABLE] & ~r.gate;
    ate         = r.ctrl_a[acs_pkg::A_ATE];
    tsel        = r.ctrl_b[acs_pkg::B_TSEL +: 3];
    busy        = (r.phase != acs_pkg::ACS_IDLE);
    a           = r.ap.addr;
    wr          = r.ap.htrans_ok & r.ap.hwrite;
    rd          = r.ap.htrans_ok & ~r.ap.hwrite;
    done_evt    = 1'b0;
    next_r.sample = 1'b0;
    next_r.clk_en = 1'b0;

    // bus address phase
    next_r.ap.htrans_ok = hsel & hready & htrans[1];
    next_r.ap.hwrite    = hwrite;
    next_r.ap.addr      = haddr[11:0];

    // trigger synchronisers, change counted when second and third agree
    next_r.s1 = trig_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.lvl = (r.s2 & r.s3) | (r.lvl & (r.s2 | r.s3));
    trig_ok    = next_r.lvl & ~r.lvl;
    next_r.tflag = r.tflag | trig_ok;

    // prescaler, half tick every masked count
    half_tick = enable && ((r.pre & div_mask(r.ctrl_a[acs_pkg::A_PRESCALE +: 3])) ==
                           div_mask(r.ctrl_a[acs_pkg::A_PRESCALE +: 3]));
    next_r.pre = enable ? 7'(r.pre + 7'h01) : 7'h00;
    if (half_tick)
    begin
      next_r.pre  = 7'h00;
      next_r.half = ~r.half;
      next_r.clk_en = ~r.half;
    end
    if (!enable)
    begin
      next_r.half  = 1'b0;
      next_r.first = 1'b1;
    end

    // trigger source edge; done flag as source means free running
    trig_edge   = r.tflag[tsel] & ~r.src_prev;
    next_r.src_prev = r.tflag[tsel];

    unique case (r.phase)
      acs_pkg::ACS_IDLE:
      begin
        if (enable && r.start_pend)
          next_r.phase = acs_pkg::ACS_WAIT;
        else if (enable && ate && trig_edge && tsel != acs_pkg::TSEL_FREE)
        begin
          next_r.pre   = 7'h00;
          next_r.half  = 1'b0;
          next_r.phase = acs_pkg::ACS_CONV;
          next_r.kind  = r.first ? acs_pkg::ACS_K_FIRST : acs_pkg::ACS_K_AUTO;
          next_r.hcnt  = 6'h00;
          next_r.first = 1'b0;
          next_r.ctrl_a[acs_pkg::A_START] = 1'b1;
        end
      end
      acs_pkg::ACS_WAIT:
        if (half_tick && !r.half)
        begin
          next_r.phase = acs_pkg::ACS_CONV;
          next_r.kind  = r.first ? acs_pkg::ACS_K_FIRST : acs_pkg::ACS_K_NORMAL;
          next_r.hcnt  = 6'h00;
          next_r.first = 1'b0;
          next_r.start_pend = 1'b0;
        end
      acs_pkg::ACS_CONV:
        if (half_tick)
        begin
          next_r.hcnt = 6'(r.hcnt + 6'h01);
          if (6'(r.hcnt + 6'h01) == sh_point(r.kind))
            next_r.sample = 1'b1;
          if (6'(r.hcnt + 6'h01) == conv_len(r.kind))
            done_evt = 1'b1;
        end
    endcase

    // buffer tracks writes outside a conversion and in its last cycle
    if (!busy || r.phase == acs_pkg::ACS_WAIT ||
        (r.phase == acs_pkg::ACS_CONV && 6'(conv_len(r.kind) - r.hcnt) <= acs_pkg::HALF_LAST))
      next_r.sel_buf = r.sel_sw;

    if (done_evt)
    begin
      next_r.ctrl_a[acs_pkg::A_DONE] = 1'b1;
      if (!r.locked)
        next_r.result = conv_code;
      if (ate && tsel == acs_pkg::TSEL_FREE)
      begin
        next_r.hcnt = 6'h00;
        next_r.kind = acs_pkg::ACS_K_FREE;
      end
      else
      begin
        next_r.phase = acs_pkg::ACS_IDLE;
        next_r.ctrl_a[acs_pkg::A_START] = 1'b0;
      end
    end

    // register reads
    adj = r.ctrl_b[acs_pkg::B_LADJ] ? {r.result, 6'h00} : {6'h00, r.result};
    next_r.rdata = 32'h0000_0000;
    if (next_r.ap.htrans_ok && !hwrite)
      unique case (haddr[11:0])
        acs_pkg::OFS_POWER:  next_r.rdata = {31'h0000_0000, r.gate};
        acs_pkg::OFS_CTRL_A: next_r.rdata = {24'h00_0000, r.ctrl_a};
        acs_pkg::OFS_CTRL_B: next_r.rdata = {28'h000_0000, r.ctrl_b};
        acs_pkg::OFS_INSEL:  next_r.rdata = {24'h00_0000, r.sel_sw.ref_sel, 2'h0,
                                             r.sel_sw.chan};
        acs_pkg::OFS_RES_LO: next_r.rdata = {24'h00_0000, adj[7:0]};
        acs_pkg::OFS_RES_HI: next_r.rdata = {24'h00_0000, adj[15:8]};
        acs_pkg::OFS_TRIG:   next_r.rdata = {24'h00_0000, r.tflag};
        default:             next_r.rdata = 32'h0000_0000;
      endcase
    if (rd && a == acs_pkg::OFS_RES_LO)
      next_r.locked = 1'b1;
    if (rd && a == acs_pkg::OFS_RES_HI)
      next_r.locked = 1'b0;

    // register writes; hardware set beats software clear
    if (irq_ack)
      next_r.ctrl_a[acs_pkg::A_DONE] = done_evt;
    if (wr)
      unique case (a)
        acs_pkg::OFS_POWER:  next_r.gate = hwdata[acs_pkg::P_GATE];
        acs_pkg::OFS_CTRL_A:
        begin
          next_r.ctrl_a[acs_pkg::A_ENABLE] = hwdata[acs_pkg::A_ENABLE];
          next_r.ctrl_a[acs_pkg::A_ATE]    = hwdata[acs_pkg::A_ATE];
          next_r.ctrl_a[acs_pkg::A_IE]     = hwdata[acs_pkg::A_IE];
          next_r.ctrl_a[acs_pkg::A_PRESCALE +: 3] = hwdata[acs_pkg::A_PRESCALE +: 3];
          if (hwdata[acs_pkg::A_DONE] && !done_evt)
            next_r.ctrl_a[acs_pkg::A_DONE] = 1'b0;
          if (hwdata[acs_pkg::A_START] && hwdata[acs_pkg::A_ENABLE] && !r.gate)
          begin
            next_r.ctrl_a[acs_pkg::A_START] = 1'b1;
            if (!busy)
              next_r.start_pend = 1'b1;
          end
        end
        acs_pkg::OFS_CTRL_B: next_r.ctrl_b = hwdata[3:0];
        acs_pkg::OFS_INSEL:
        begin
          next_r.sel_sw.chan    = hwdata[acs_pkg::S_CHAN +: 4];
          next_r.sel_sw.ref_sel = hwdata[acs_pkg::S_REF +: 2];
        end
        acs_pkg::OFS_TRIG:   next_r.tflag = next_r.tflag &
                                            ~(hwdata[7:0] & ~trig_ok);
        default: ;
      endcase

    // done flag feeds trigger slot zero
    next_r.tflag[acs_pkg::TSEL_FREE] = next_r.ctrl_a[acs_pkg::A_DONE];

    // a write that switches the converter on keeps its start request
    if (!(next_r.ctrl_a[acs_pkg::A_ENABLE] & ~next_r.gate))
    begin
      next_r.phase = acs_pkg::ACS_IDLE;
      next_r.start_pend = 1'b0;
      next_r.ctrl_a[acs_pkg::A_START] = 1'b0;
    end
    next_r.pwr = next_r.ctrl_a[acs_pkg::A_ENABLE] & ~next_r.gate;
    next_r.irq = next_r.ctrl_a[acs_pkg::A_DONE] & next_r.ctrl_a[acs_pkg::A_IE];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      r       <= '0;
      r.gate  <= acs_pkg::POWER_RESET;
      r.first <= 1'b1;
      r.phase <= acs_pkg::ACS_IDLE;
      r.kind  <= acs_pkg::ACS_K_NORMAL;
    end
    else
      r <= next_r;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign hrdata      = r.rdata;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign conv_power  = r.pwr;
  assign conv_sel    = r.sel_buf;
  assign conv_sample = r.sample;
  assign conv_clk_en = r.clk_en;
  assign done_irq    = r.irq;

  // ****************************************
  // checks
  // ****************************************
  sequence start_write_s;
    r.ap.htrans_ok && r.ap.hwrite && r.ap.addr == acs_pkg::OFS_CTRL_A &&
    hwdata[acs_pkg::A_START] && hwdata[acs_pkg::A_ENABLE] && !r.gate;
  endsequence

  start_reads_a: assert property (@(posedge hclk) disable iff (!hresetn)
    start_write_s |=> r.ctrl_a[acs_pkg::A_START])
    else $error("start bit not set after write");
  busy_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.phase == acs_pkg::ACS_CONV |-> r.ctrl_a[acs_pkg::A_START])
    else $error("start bit low during conversion");
  done_sets_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done_evt |=> r.ctrl_a[acs_pkg::A_DONE])
    else $error("done flag missed");
  lock_holds_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.locked && !(rd && a == acs_pkg::OFS_RES_HI) |=> $stable(r.result))
    else $error("result changed while locked");
  off_power_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !r.ctrl_a[acs_pkg::A_ENABLE] |-> !conv_power)
    else $error("power while disabled");
  sel_locked_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.phase == acs_pkg::ACS_CONV && r.hcnt < acs_pkg::SH_NORMAL && !done_evt
    |=> $stable(r.sel_buf))
    else $error("selection moved during conversion");
  pre_reset_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !enable |=> r.pre == 7'h00 && !r.half)
    else $error("prescaler ran while disabled");
  single_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
    done_evt && !(ate && tsel == acs_pkg::TSEL_FREE) |=> r.phase == acs_pkg::ACS_IDLE)
    else $error("single conversion did not end");
endmodule

// ### rtl/acs_pkg.sv
// package: register map, field layout and timing constants of the conversion sequencer
package acs_pkg;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [11:0] OFS_POWER   = 12'h000;  // power_reduction_reg
  localparam logic [11:0] OFS_CTRL_A  = 12'h004;  // converter_control_a
  localparam logic [11:0] OFS_CTRL_B  = 12'h008;  // converter_control_b
  localparam logic [11:0] OFS_INSEL   = 12'h00C;  // input_select_reg
  localparam logic [11:0] OFS_RES_LO  = 12'h010;  // result_low_byte
  localparam logic [11:0] OFS_RES_HI  = 12'h014;  // result_high_byte
  localparam logic [11:0] OFS_TRIG    = 12'h018;  // trigger source flags, write one clears

  // ****************************************
  // field positions
  // ****************************************
  localparam int A_PRESCALE  = 0;   // converter_control_a [2:0]
  localparam int A_IE        = 3;
  localparam int A_DONE      = 4;   // conversion_done_flag
  localparam int A_ATE       = 5;   // auto_trigger_enable
  localparam int A_START     = 6;   // start_conversion_bit
  localparam int A_ENABLE    = 7;   // converter_enable_bit
  localparam int B_TSEL      = 0;   // trigger_source_select [2:0]
  localparam int B_LADJ      = 3;   // left_adjust_select
  localparam int S_CHAN      = 0;   // channel_select [3:0]
  localparam int S_REF       = 6;   // reference_select [1:0]
  localparam int P_GATE      = 0;   // converter_power_gate_bit

  localparam int          NTRIG       = 8;
  localparam logic [2:0]  TSEL_FREE   = 3'h0;   // done flag as trigger source
  localparam logic        POWER_RESET = 1'b1;   // converter gated after reset

  // ****************************************
  // timing, in converter clock half cycles
  // ****************************************
  localparam logic [5:0] HALF_NORMAL   = 6'h1A;  // 13 cycles
  localparam logic [5:0] HALF_FIRST    = 6'h32;  // 25 cycles
  localparam logic [5:0] HALF_AUTO     = 6'h1B;  // 13.5 cycles
  localparam logic [5:0] HALF_FREE     = 6'h1C;  // 14 cycles
  localparam logic [5:0] SH_NORMAL     = 6'h03;  // 1.5 cycles
  localparam logic [5:0] SH_FIRST      = 6'h1B;  // 13.5 cycles
  localparam logic [5:0] SH_AUTO       = 6'h04;  // 2 cycles
  localparam logic [5:0] SH_FREE       = 6'h05;  // 2.5 cycles
  localparam logic [5:0] HALF_LAST     = 6'h02;  // last converter cycle

  typedef enum logic [1:0] {ACS_K_NORMAL, ACS_K_FIRST, ACS_K_AUTO, ACS_K_FREE} acs_kind_t;
  typedef enum {ACS_IDLE, ACS_WAIT, ACS_CONV} acs_phase_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic [3:0] chan;
  } acs_sel_t;

  typedef struct packed {
    logic       htrans_ok;
    logic       hwrite;
    logic [11:0] addr;
  } acs_aphase_t;
endpackage

// ### tb/acs_front.sv
// partner model: analog front end and trigger sources facing the sequencer
`timescale 1ns/1ps
module acs_front
(
  input  wire logic              hclk,        // system clock
  input  wire logic              hresetn,     // reset, active low
  input  wire logic              conv_power,  // converter supplied
  input  wire acs_pkg::acs_sel_t conv_sel,    // applied reference and channel
  input  wire logic              conv_sample, // sample-and-hold pulse
  input  wire logic [7:0]        trig_req,    // trigger levels asked by the bench
  output logic      [7:0]        trig_in,     // trigger sources
  output logic      [9:0]        conv_code    // converted value
);
  // ****************************************
  // converter: code names the sampled selection
  // ****************************************
  assign trig_in = trig_req;
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      conv_code <= 10'h2AA;
    else if (!conv_power)
      conv_code <= ~conv_code;
    else if (conv_sample)
      conv_code <= {conv_sel.ref_sel, conv_sel.chan, 4'hA};
  end
endmodule

// ### tb/testbench.sv
// testbench: register level tests of the conversion sequencer
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] C_RUN = 32'h0000_008A;  // enable, irq enable, divide by 4
  localparam logic [31:0] C_GO  = 32'h0000_00CA;
  localparam logic [31:0] C_AT  = 32'h0000_00AA;
  localparam logic [31:0] C_ATG = 32'h0000_00EA;
  localparam logic [31:0] C_ST  = 32'h0000_0040;
  localparam logic [31:0] M8    = 32'h0000_00FF;
  localparam int          DIV   = 4;
  logic              hclk    = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel    = 1'b0;
  logic [31:0]       haddr   = 32'h0000_0000;
  logic [1:0]        htrans  = 2'h0;
  logic              hwrite  = 1'b0;
  logic [2:0]        hsize   = 3'h2;
  logic [31:0]       hwdata  = 32'h0000_0000;
  logic [7:0]        trig_req = 8'h00;
  logic              irq_ack = 1'b0;
  logic              done_d  = 1'b0;
  logic [31:0]       hrdata;
  logic              hreadyout;
  logic              hresp;
  logic [7:0]        trig_in;
  logic [9:0]        conv_code;
  logic              conv_power;
  logic              conv_sample;
  logic              conv_clk_en;
  logic              done_irq;
  acs_pkg::acs_sel_t conv_sel;
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int n_done = 0;
  int n_ck = 0;
  int t_done = 0;
  int t_smp = 0;
  int t_smp0 = 0;
  int t_ck = 0;
  int gap_ck = 0;
  int t0;
  int k;

  always #10 hclk = ~hclk;

  acs_sequencer u_dut
  (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trig_in(trig_in),
    .irq_ack(irq_ack), .conv_code(conv_code), .conv_power(conv_power),
    .conv_sel(conv_sel), .conv_sample(conv_sample), .conv_clk_en(conv_clk_en),
    .done_irq(done_irq)
  );
  acs_front u_front
  (
    .hclk(hclk), .hresetn(hresetn), .conv_power(conv_power), .conv_sel(conv_sel),
    .conv_sample(conv_sample), .trig_req(trig_req), .trig_in(trig_in),
    .conv_code(conv_code)
  );

  // ****************************************
  // monitor: event times, interrupt service
  // ****************************************
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    done_d <= done_irq;
    irq_ack <= (done_irq === 1'b1) && !irq_ack;
    if (done_irq === 1'b1 && !done_d)
    begin
      n_done <= n_done + 1;
      t_done <= cyc;
    end
    if (conv_sample === 1'b1)
    begin
      t_smp0 <= t_smp;
      t_smp <= cyc;
    end
    if (conv_clk_en === 1'b1)
    begin
      gap_ck <= cyc - t_ck;
      t_ck <= cyc;
      n_ck <= n_ck + 1;
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rng(string name, int v, int lo, int hi);
    check(name, 32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] wd, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(string n, logic [11:0] a, logic [31:0] m, logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(n, x & m, e);
  endtask
  task automatic wait_done(int n);
    int target;
    int w;
    target = n_done + n;
    w = 0;
    while (n_done < target && w < 4000)
    begin
      @(posedge hclk);
      w++;
    end
    check("completion wait", 32'(n_done >= target), 32'h0000_0001);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("power reset", acs_pkg::OFS_POWER, M8, 32'h0000_0001);
    rdc("ctrl_a reset", acs_pkg::OFS_CTRL_A, M8, 32'h0000_0000);
    rdc("ctrl_b reset", acs_pkg::OFS_CTRL_B, M8, 32'h0000_0000);
    rdc("unmapped", 12'h01C, 32'hFFFF_FFFF, 32'h0000_0000);
    check("okay response", 32'(hresp), 32'h0000_0000);
    wr(acs_pkg::OFS_CTRL_A, C_GO);
    rdc("gated start", acs_pkg::OFS_CTRL_A, C_ST, 32'h0000_0000);
    check("gated power", 32'(conv_power), 32'h0000_0000);
    $display("test reset done");
    wr(acs_pkg::OFS_POWER, 32'h0000_0000);
    for (int p = 0; p < 8; p++)
    begin
      wr(acs_pkg::OFS_CTRL_A, 32'h0000_0080 | p);
      repeat (3) @(posedge hclk iff conv_clk_en);
      check("prescale gap", gap_ck, (p < 2) ? 2 : (1 << p));
    end
    wr(acs_pkg::OFS_CTRL_A, 32'h0000_0000);
    k = n_ck;
    repeat (300) @(posedge hclk);
    check("prescaler held", n_ck - k, 32'h0000_0000);
    $display("test prescaler done");
    wr(acs_pkg::OFS_INSEL, 32'h0000_0043);
    t0 = cyc;
    wr(acs_pkg::OFS_CTRL_A, C_GO);
    rdc("start busy", acs_pkg::OFS_CTRL_A, C_ST, C_ST);
    wait_done(1);
    rng("first length", t_done - t0, 25 * DIV + 1, 25 * DIV + 9);
    rng("first hold", t_done - t_smp, 45, 47);
    rdc("start cleared", acs_pkg::OFS_CTRL_A, C_ST, 32'h0000_0000);
    rdc("low byte", acs_pkg::OFS_RES_LO, M8, 32'h0000_003A);
    wr(acs_pkg::OFS_INSEL, 32'h0000_0045);
    t0 = cyc;
    wr(acs_pkg::OFS_CTRL_A, C_GO);
    wait_done(1);
    rng("normal length", t_done - t0, 13 * DIV + 1, 13 * DIV + 9);
    rng("normal hold", t_done - t_smp, 45, 47);
    rdc("locked high", acs_pkg::OFS_RES_HI, M8, 32'h0000_0001);
    rdc("locked low", acs_pkg::OFS_RES_LO, M8, 32'h0000_003A);
    rdc("unlock high", acs_pkg::OFS_RES_HI, M8, 32'h0000_0001);
    $display("test single done");
    wr(acs_pkg::OFS_CTRL_B, 32'h0000_0008);
    wr(acs_pkg::OFS_CTRL_A, C_GO);
    repeat (2) @(posedge hclk iff conv_clk_en);
    wr(acs_pkg::OFS_INSEL, 32'h0000_0047);
    wait_done(1);
    rdc("left low", acs_pkg::OFS_RES_LO, M8, 32'h0000_0080);
    rdc("left high", acs_pkg::OFS_RES_HI, M8, 32'h0000_0056);
    check("applied sel", 32'(conv_sel), 32'h0000_0017);
    $display("test adjust done");
    wr(acs_pkg::OFS_CTRL_B, 32'h0000_000A);
    wr(acs_pkg::OFS_CTRL_A, C_AT);
    @(posedge hclk);
    trig_req <= 8'h04;
    t0 = cyc;
    wait_done(1);
    rng("trigger hold", t_smp - t0, 2 * DIV + 1, 2 * DIV + 6);
    rdc("trigger flag", acs_pkg::OFS_TRIG, 32'h0000_0004, 32'h0000_0004);
    rdc("auto low", acs_pkg::OFS_RES_LO, M8, 32'h0000_0080);
    rdc("auto high", acs_pkg::OFS_RES_HI, M8, 32'h0000_005E);
    k = n_done;
    repeat (300) @(posedge hclk);
    check("held trigger", n_done - k, 32'h0000_0000);
    wr(acs_pkg::OFS_TRIG, 32'h0000_0004);
    trig_req <= 8'h00;
    repeat (4) @(posedge hclk);
    trig_req <= 8'h04;
    wait_done(1);
    wr(acs_pkg::OFS_CTRL_A, C_ATG);
    rdc("auto start busy", acs_pkg::OFS_CTRL_A, C_ST, C_ST);
    wait_done(1);
    $display("test trigger done");
    wr(acs_pkg::OFS_CTRL_B, 32'h0000_0008);
    wr(acs_pkg::OFS_CTRL_A, C_ATG);
    wait_done(3);
    rng("free period", t_smp - t_smp0, 14 * DIV - 1, 14 * DIV + 1);
    rdc("free start", acs_pkg::OFS_CTRL_A, C_ST, C_ST);
    wr(acs_pkg::OFS_CTRL_A, 32'h0000_0000);
    @(posedge hclk);
    check("power off", 32'(conv_power), 32'h0000_0000);
    $display("test free running done");
    report_and_stop;
  end

  initial
  begin
    #400000;
    errors++;
    report_and_stop;
  end
endmodule
